// File: design/embi_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - drive data only on own write cycles
// - I/O request low on I/O accesses
// - memory request low on memory accesses
// - space requests undriven during reset
// - read strobe low while reading
// - write strobe low while writing
// - fetch flag with memory read fetch
// - strobes float while bus granted
// - wait input low extends the cycle
// - reset pin bidirectional, open-drain pull
// - NMI falling edge, beats maskable
// - NMI taken at instruction end
// - float outputs, then assert grant
// - address and space lines inputs when granted
// - external address feeds chip selects
// - chip select low within its range
module embi_bus_if (
  // clock and reset
  input  wire logic                           clock,
  input  wire logic                           rst_b,
  // core access port
  input  wire logic                           req_valid,
  input  wire logic                           req_write,
  input  wire logic                           req_io,
  input  wire logic                           req_fetch,
  input  wire logic [embi_pkg::ADDR_W-1:0]    req_addr,
  input  wire logic [embi_pkg::DATA_W-1:0]    req_wdata,
  output logic                                req_ready,
  output logic                                req_done,
  output logic [embi_pkg::DATA_W-1:0]         req_rdata,
  // core interrupt and reset port
  input  wire logic                           instr_end,
  input  wire logic                           irq_req,
  input  wire logic                           irq_enable,
  input  wire logic                           int_reset_req,
  output logic                                nmi_take,
  output logic                                irq_take,
  output logic                                core_reset_n,
  // address and data pins
  input  wire logic [embi_pkg::ADDR_W-1:0]    addr_i,
  output logic [embi_pkg::ADDR_W-1:0]         addr_o,
  output logic                                addr_oe_n,
  input  wire logic [embi_pkg::DATA_W-1:0]    data_i,
  output logic [embi_pkg::DATA_W-1:0]         data_o,
  output logic                                data_oe_n,
  // control pins
  input  wire logic                           io_space_request_n_i,
  output logic                                io_space_request_n_o,
  output logic                                io_space_request_n_oe_n,
  input  wire logic                           memory_space_request_n_i,
  output logic                                memory_space_request_n_o,
  output logic                                memory_space_request_n_oe_n,
  output logic                                read_strobe_n_o,
  output logic                                read_strobe_n_oe_n,
  output logic                                write_strobe_n_o,
  output logic                                write_strobe_n_oe_n,
  output logic                                opcode_fetch_flag_n_o,
  output logic                                opcode_fetch_flag_n_oe_n,
  input  wire logic                           wait_n_i,
  // reset, interrupt, bus release and chip select pins
  input  wire logic                           reset_pin_n_i,
  output logic                                reset_pin_n_o,
  output logic                                reset_pin_n_oe_n,
  input  wire logic                           nmi_n_i,
  input  wire logic                           bus_release_request_n,
  output logic                                bus_release_grant_n,
  output logic [embi_pkg::CS_NUM-1:0]         chip_select_n
);
  import embi_pkg::*;

  embi_state_t         state_q, state_d;
  logic [ADDR_W-1:0]   ext_addr_s1, ext_addr_s2;
  logic [DATA_W-1:0]   data_s1, data_s2;
  logic                ext_io_s1, ext_io_s2, ext_mem_s1, ext_mem_s2;
  logic                wait_s1, wait_s2, bus_release_request_n_s1, bus_release_request_n_s2;
  logic                rstpin_s1, rstpin_s2;
  logic                nmi_s1, nmi_s2, nmi_s3, nmi_pend_q;
  logic [ADDR_W-1:0]   op_addr_q, cur_addr;
  logic [DATA_W-1:0]   op_wdata_q, cur_wdata;
  logic                op_wr_q, op_io_q, op_fetch_q, cur_wr, cur_io, cur_fetch;
  logic [WAIT_W-1:0]   wcnt_q, load_wait;
  logic [HOLD_W-1:0]   hold_q, hold_d;
  logic [CS_NUM-1:0]   cs_own, cs_ext;
  logic                in_rst, take, drv_d, grant_d;

  // pins come from outside the clock domain
  always_ff @(posedge clock) begin
    ext_addr_s1 <= addr_i;
    ext_addr_s2 <= ext_addr_s1;
    data_s1     <= data_i;
    data_s2     <= data_s1;
    ext_io_s1   <= io_space_request_n_i;
    ext_io_s2   <= ext_io_s1;
    ext_mem_s1  <= memory_space_request_n_i;
    ext_mem_s2  <= ext_mem_s1;
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wait_s1   <= 1'b1;
      wait_s2   <= 1'b1;
      bus_release_request_n_s1 <= 1'b1;
      bus_release_request_n_s2 <= 1'b1;
      rstpin_s1 <= 1'b1;
      rstpin_s2 <= 1'b1;
      nmi_s1    <= 1'b1;
      nmi_s2    <= 1'b1;
      nmi_s3    <= 1'b1;
    end else begin
      wait_s1   <= wait_n_i;
      wait_s2   <= wait_s1;
      bus_release_request_n_s1 <= bus_release_request_n;
      bus_release_request_n_s2 <= bus_release_request_n_s1;
      rstpin_s1 <= reset_pin_n_i;
      rstpin_s2 <= rstpin_s1;
      nmi_s1    <= nmi_n_i;
      nmi_s2    <= nmi_s1;
      nmi_s3    <= nmi_s2;
    end
  end

  assign in_rst = !rstpin_s2 || (hold_q != HOLD_ZERO);

  always_comb begin
    hold_d = hold_q;
    if (hold_q != HOLD_ZERO) begin
      hold_d = hold_q - 8'h01;
    end else if (int_reset_req) begin
      hold_d = RESET_HOLD_CYC;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      hold_q           <= HOLD_ZERO;
      reset_pin_n_o    <= 1'b0;
      reset_pin_n_oe_n <= 1'b1;
      core_reset_n     <= 1'b0;
    end else begin
      hold_q           <= hold_d;
      reset_pin_n_o    <= 1'b0;
      reset_pin_n_oe_n <= (hold_d == HOLD_ZERO);
      core_reset_n     <= !in_rst;
    end
  end

  // chip select decode, own or external address
  function automatic logic [CS_NUM-1:0] cs_hit(input logic [ADDR_W-1:0] a, input logic io);
    cs_hit = '0;
    for (int i = 0; i < CS_NUM; i++) begin
      cs_hit[i] = (CS_IS_IO[i] == io) && (a >= CS_BASE[i]) && (a <= CS_LAST[i]);
    end
  endfunction

  always_comb begin
    load_wait = WAIT_NONE;
    for (int i = 0; i < CS_NUM; i++) begin
      if (cs_hit(req_addr, req_io) == (4'h1 << i)) begin
        load_wait = CS_WAIT[i];
      end
    end
  end

  assign take = req_valid && (state_q == EMBI_IDLE) && bus_release_request_n_s2 && !in_rst;

  always_comb begin
    state_d = state_q;
    case (state_q)
      EMBI_IDLE: begin
        if (!in_rst && !bus_release_request_n_s2) begin
          state_d = EMBI_GRANT;
        end else if (take) begin
          state_d = EMBI_T1;
        end
      end
      EMBI_T1: state_d = EMBI_T2;
      EMBI_T2: begin
        if (wcnt_q == WAIT_NONE && wait_s2) begin
          state_d = EMBI_T3;
        end
      end
      EMBI_T3: state_d = EMBI_IDLE;
      EMBI_GRANT: begin
        if (bus_release_request_n_s2) begin
          state_d = EMBI_IDLE;
        end
      end
      default: state_d = EMBI_IDLE;
    endcase
    if (in_rst) begin
      state_d = EMBI_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_q <= EMBI_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      op_addr_q  <= '0;
      op_wdata_q <= '0;
      op_wr_q    <= 1'b0;
      op_io_q    <= 1'b0;
      op_fetch_q <= 1'b0;
    end else if (take) begin
      op_addr_q  <= req_addr;
      op_wdata_q <= req_wdata;
      op_wr_q    <= req_write;
      op_io_q    <= req_io;
      op_fetch_q <= req_fetch;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wcnt_q <= WAIT_NONE;
    end else if (take) begin
      wcnt_q <= load_wait;
    end else if (state_q == EMBI_T2 && wcnt_q != WAIT_NONE) begin
      wcnt_q <= wcnt_q - 3'h1;
    end
  end

  // pins update on the edge that starts the state
  assign cur_addr  = take ? req_addr : op_addr_q;
  assign cur_wdata = take ? req_wdata : op_wdata_q;
  assign cur_wr    = take ? req_write : op_wr_q;
  assign cur_io    = take ? req_io : op_io_q;
  assign cur_fetch = take ? req_fetch : op_fetch_q;
  assign drv_d     = (state_d == EMBI_T1) || (state_d == EMBI_T2) || (state_d == EMBI_T3);
  assign grant_d   = (state_d == EMBI_GRANT);
  assign cs_own    = drv_d ? cs_hit(cur_addr, cur_io) : '0;
  assign cs_ext    = (!ext_mem_s2 ? cs_hit(ext_addr_s2, 1'b0) : '0) |
                     (!ext_io_s2 ? cs_hit(ext_addr_s2, 1'b1) : '0);

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      addr_o                      <= '0;
      addr_oe_n                   <= 1'b1;
      data_o                      <= '0;
      data_oe_n                   <= 1'b1;
      io_space_request_n_o        <= 1'b1;
      io_space_request_n_oe_n     <= 1'b1;
      memory_space_request_n_o    <= 1'b1;
      memory_space_request_n_oe_n <= 1'b1;
      read_strobe_n_o             <= 1'b1;
      read_strobe_n_oe_n          <= 1'b1;
      write_strobe_n_o            <= 1'b1;
      write_strobe_n_oe_n         <= 1'b1;
      opcode_fetch_flag_n_o       <= 1'b1;
      opcode_fetch_flag_n_oe_n    <= 1'b1;
      chip_select_n               <= '1;
    end else begin
      addr_o                      <= cur_addr;
      addr_oe_n                   <= grant_d;
      data_o                      <= cur_wdata;
      data_oe_n                   <= !(drv_d && cur_wr);
      io_space_request_n_o        <= !(drv_d && cur_io);
      io_space_request_n_oe_n     <= in_rst || grant_d;
      memory_space_request_n_o    <= !(drv_d && !cur_io);
      memory_space_request_n_oe_n <= in_rst || grant_d;
      read_strobe_n_o             <= !(drv_d && !cur_wr);
      read_strobe_n_oe_n          <= grant_d;
      write_strobe_n_o            <= !(drv_d && cur_wr);
      write_strobe_n_oe_n         <= grant_d;
      opcode_fetch_flag_n_o       <= !(drv_d && cur_fetch && !cur_wr && !cur_io);
      opcode_fetch_flag_n_oe_n    <= grant_d;
      chip_select_n               <= ~((state_q == EMBI_GRANT && grant_d) ? cs_ext : cs_own);
    end
  end

  // grant one edge after the float
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      bus_release_grant_n <= 1'b1;
    end else begin
      bus_release_grant_n <= !(state_q == EMBI_GRANT && grant_d);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      req_ready <= 1'b0;
      req_done  <= 1'b0;
      req_rdata <= '0;
    end else begin
      req_ready <= (state_d == EMBI_IDLE) && !in_rst;
      req_done  <= (state_q == EMBI_T3);
      if (state_q == EMBI_T3 && !op_wr_q) begin
        req_rdata <= data_s2;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      nmi_pend_q <= 1'b0;
      nmi_take   <= 1'b0;
      irq_take   <= 1'b0;
    end else begin
      nmi_pend_q <= (nmi_s3 && !nmi_s2) || (nmi_pend_q && !instr_end && !in_rst);
      nmi_take   <= instr_end && nmi_pend_q && !in_rst;
      irq_take   <= instr_end && !nmi_pend_q && irq_req && irq_enable && !in_rst;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_data_own_write: assert property (
    !data_oe_n |-> op_wr_q && state_q inside {EMBI_T1, EMBI_T2, EMBI_T3})
    else $error("data driven outside own write");
  a_io_space_req: assert property (
    !io_space_request_n_o |-> op_io_q && !io_space_request_n_oe_n)
    else $error("io request without io access");
  a_mem_space_req: assert property (
    take && !req_io ##1 !in_rst |-> !memory_space_request_n_o)
    else $error("memory request missing");
  a_reset_float: assert property (
    in_rst |=> io_space_request_n_oe_n && memory_space_request_n_oe_n)
    else $error("space request driven in reset");
  a_read_strobe: assert property (
    take && !req_write |=> !read_strobe_n_o && write_strobe_n_o)
    else $error("read strobe wrong");
  a_write_strobe: assert property (
    !write_strobe_n_o |-> op_wr_q && read_strobe_n_o)
    else $error("write strobe wrong");
  a_fetch_with_rd: assert property (
    !opcode_fetch_flag_n_o |-> !read_strobe_n_o && !memory_space_request_n_o)
    else $error("fetch flag alone");
  a_grant_float: assert property (
    !bus_release_grant_n |-> read_strobe_n_oe_n && write_strobe_n_oe_n && addr_oe_n
      && opcode_fetch_flag_n_oe_n && data_oe_n && memory_space_request_n_oe_n)
    else $error("driving while granted");
  a_wait_extend: assert property (
    state_q == EMBI_T2 && !wait_s2 && !in_rst |=> state_q == EMBI_T2)
    else $error("wait ignored");
  a_reset_pull: assert property (
    int_reset_req && hold_q == HOLD_ZERO |=> !reset_pin_n_oe_n [*3])
    else $error("reset pin not pulled");
  a_nmi_first: assert property (
    instr_end && nmi_pend_q && !in_rst |=> nmi_take && !irq_take)
    else $error("nmi lost priority");
  a_nmi_edge: assert property (
    nmi_s3 && !nmi_s2 ##1 instr_end && !in_rst |=> nmi_take)
    else $error("nmi not taken");
  a_grant_entry: assert property (
    state_q == EMBI_GRANT && $past(state_q) != EMBI_GRANT |-> $past(state_q) == EMBI_IDLE)
    else $error("grant mid cycle");

  c_write_cycle: cover property (take && req_write ##4 req_done);
  c_wait_cycle: cover property (state_q == EMBI_T2 && !wait_s2 ##1 state_q == EMBI_T2);
  c_bus_grant: cover property ($fell(bus_release_grant_n) ##[1:20] $rose(bus_release_grant_n));
  c_nmi_taken: cover property (nmi_take);
endmodule : embi_bus_if
`default_nettype wire

// File: design/embi_pkg.sv
package embi_pkg;
  // bus widths
  localparam int ADDR_W = 24;
  localparam int DATA_W = 8;
  localparam int CS_NUM = 4;

  // chip select windows, fixed at build time since there is no register access
  localparam logic [23:0] CS_BASE [CS_NUM] = '{24'h000000, 24'h100000, 24'h800000, 24'h000080};
  localparam logic [23:0] CS_LAST [CS_NUM] = '{24'h0FFFFF, 24'h1FFFFF, 24'hFFFFFF, 24'h0000FF};
  localparam logic [CS_NUM-1:0] CS_IS_IO = 4'h8;
  localparam int WAIT_W = 3;
  localparam logic [WAIT_W-1:0] CS_WAIT [CS_NUM] = '{3'h1, 3'h0, 3'h2, 3'h3};
  localparam logic [WAIT_W-1:0] WAIT_NONE = 3'h0;

  // reset pin pull-low length
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_HOLD_NS = 1000;
  localparam int HOLD_W = 8;
  localparam logic [HOLD_W-1:0] RESET_HOLD_CYC =
    HOLD_W'((RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [HOLD_W-1:0] HOLD_ZERO = 8'h00;

  // bus cycle sequencer, gray along idle-t1-t2-t3
  typedef enum logic [2:0] {
    EMBI_IDLE  = 3'h0,
    EMBI_T1    = 3'h1,
    EMBI_T2    = 3'h3,
    EMBI_T3    = 3'h2,
    EMBI_GRANT = 3'h6
  } embi_state_t;
endpackage : embi_pkg

// File: tb/embi_bus_if_tb.sv
`timescale 1ns/1ps
`default_nettype none
module embi_bus_if_tb;
  import embi_pkg::*;
  logic        clock, rst_b, req_valid, req_write, req_io, req_fetch;
  logic [23:0] req_addr, addr_i, addr_o, m_addr;
  logic [7:0]  req_wdata, req_rdata, data_i, data_o, m_data;
  logic        req_ready, req_done, instr_end, irq_req, irq_enable, int_reset_req;
  logic        nmi_take, irq_take, core_reset_n, addr_oe_n, data_oe_n;
  logic        io_space_request_n_i, io_space_request_n_o, io_space_request_n_oe_n;
  logic        memory_space_request_n_i, memory_space_request_n_o, memory_space_request_n_oe_n;
  logic        read_strobe_n_o, read_strobe_n_oe_n, write_strobe_n_o, write_strobe_n_oe_n;
  logic        opcode_fetch_flag_n_o, opcode_fetch_flag_n_oe_n, wait_n_i;
  logic        reset_pin_n_i, reset_pin_n_o, reset_pin_n_oe_n, nmi_n_i;
  logic        bus_release_request_n, bus_release_grant_n;
  logic [3:0]  chip_select_n, s_cs;
  logic        slow, m_memory_space_request_n_n, m_io_n, ext_rst_n;
  logic        s_memory_space_request_n, s_io, s_rd, s_wr, s_fet, s_doe;
  int          miscompares, compares, cyc, fast;

  // wire levels from every party's enable
  assign addr_i = addr_oe_n ? m_addr : addr_o;
  assign data_i = data_oe_n ? m_data : data_o;
  assign io_space_request_n_i = io_space_request_n_oe_n ? m_io_n : io_space_request_n_o;
  assign memory_space_request_n_i =
    memory_space_request_n_oe_n ? m_memory_space_request_n_n : memory_space_request_n_o;
  assign reset_pin_n_i = reset_pin_n_oe_n ? ext_rst_n : 1'b0;

  embi_bus_if u_dut (
    .clock, .rst_b, .req_valid, .req_write, .req_io, .req_fetch, .req_addr, .req_wdata,
    .req_ready, .req_done, .req_rdata, .instr_end, .irq_req, .irq_enable, .int_reset_req,
    .nmi_take, .irq_take, .core_reset_n, .addr_i, .addr_o, .addr_oe_n, .data_i, .data_o,
    .data_oe_n, .io_space_request_n_i, .io_space_request_n_o, .io_space_request_n_oe_n,
    .memory_space_request_n_i, .memory_space_request_n_o, .memory_space_request_n_oe_n,
    .read_strobe_n_o, .read_strobe_n_oe_n, .write_strobe_n_o, .write_strobe_n_oe_n,
    .opcode_fetch_flag_n_o, .opcode_fetch_flag_n_oe_n, .wait_n_i, .reset_pin_n_i,
    .reset_pin_n_o, .reset_pin_n_oe_n, .nmi_n_i, .bus_release_request_n,
    .bus_release_grant_n, .chip_select_n
  );
  embi_mem_model u_mem (
    .clock, .slow, .addr_o, .data_o, .data_oe_n, .read_strobe_n_o, .write_strobe_n_o,
    .m_data, .wait_n_i
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic tally_and_finish();
    if (miscompares == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    compares++;
    if (got !== exp) begin
      $display("BAD %s expected %0h seen %0h", nm, exp, got);
      miscompares++;
    end
  endtask

  // one core access, recording what the pins showed until done
  task automatic acc(input logic w, io, f, input logic [23:0] a, input logic [7:0] wd);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 300) begin
      @(negedge clock);
      n++;
    end
    {req_valid, req_write, req_io, req_fetch, req_addr, req_wdata} = {1'b1, w, io, f, a, wd};
    {s_memory_space_request_n, s_io, s_rd, s_wr, s_fet, s_doe, s_cs} = '1;
    @(negedge clock);
    req_valid = 1'b0;
    cyc = 1;
    while (req_done !== 1'b1 && cyc < 60) begin
      s_memory_space_request_n &= memory_space_request_n_o | memory_space_request_n_oe_n;
      s_io &= io_space_request_n_o | io_space_request_n_oe_n;
      s_rd &= read_strobe_n_o | read_strobe_n_oe_n;
      s_wr &= write_strobe_n_o | write_strobe_n_oe_n;
      s_fet &= opcode_fetch_flag_n_o | opcode_fetch_flag_n_oe_n;
      s_doe &= data_oe_n;
      s_cs &= chip_select_n;
      @(negedge clock);
      cyc++;
    end
    chk("req_done", 1, req_done);
  endtask

  task automatic t_reset();
    chk("memory_space_request_n_oe_rst", 1, memory_space_request_n_oe_n);
    chk("io_space_request_n_oe_rst", 1, io_space_request_n_oe_n);
  endtask

  task automatic t_mem();
    acc(1'b1, 1'b0, 1'b0, 24'h000010, 8'h3C);
    chk("wr_seen", 0, s_wr);
    chk("data_drive_wr", 0, s_doe);
    chk("memory_space_request_n_seen", 0, s_memory_space_request_n);
    chk("cs_mem0", 4'hE, s_cs);
    acc(1'b0, 1'b0, 1'b0, 24'h000010, 8'h00);
    chk("rd_seen", 0, s_rd);
    chk("data_drive_rd", 1, s_doe);
    chk("fetch_plain", 1, s_fet);
    chk("rdata_mem", 8'h3C, req_rdata);
    // reference length of a plain access in the one-wait window
    fast = cyc;
    acc(1'b0, 1'b0, 1'b1, 24'h100020, 8'h00);
    chk("fetch_seen", 0, s_fet);
    chk("cs_mem1", 4'hD, s_cs);
    chk("rdata_fetch", 8'h7A, req_rdata);
  endtask

  task automatic t_io();
    acc(1'b1, 1'b1, 1'b0, 24'h000090, 8'h81);
    chk("io_space_request_n_seen", 0, s_io);
    chk("memory_space_request_n_quiet", 1, s_memory_space_request_n);
    chk("wr_io", 0, s_wr);
    chk("cs_io3", 4'h7, s_cs);
    acc(1'b0, 1'b1, 1'b0, 24'h000090, 8'h00);
    chk("rdata_io", 8'h81, req_rdata);
  endtask

  task automatic t_wait();
    // wait pin passes two flops, so only a window with its own wait count sees it in time
    slow = 1'b1;
    acc(1'b0, 1'b0, 1'b0, 24'h000010, 8'h00);
    slow = 1'b0;
    chk("wait_longer", 1, cyc > fast + 1);
    chk("rdata_wait", 8'h3C, req_rdata);
  endtask

  task automatic t_release();
    int n;
    m_addr = 24'h100040;
    bus_release_request_n = 1'b0;
    n = 0;
    while (bus_release_grant_n !== 1'b0 && n < 20) begin
      @(negedge clock);
      n++;
    end
    chk("grant", 0, bus_release_grant_n);
    chk("strobe_float", 3'h7, {read_strobe_n_oe_n, write_strobe_n_oe_n,
                               opcode_fetch_flag_n_oe_n});
    chk("addr_data_float", 2'h3, {addr_oe_n, data_oe_n});
    chk("space_inputs", 2'h3, {memory_space_request_n_oe_n, io_space_request_n_oe_n});
    m_memory_space_request_n_n = 1'b0;
    repeat (6) @(negedge clock);
    chk("cs_ext", 4'hD, chip_select_n);
    chk("ready_granted", 0, req_ready);
    bus_release_request_n = 1'b1;
    m_memory_space_request_n_n = 1'b1;
    n = 0;
    while (bus_release_grant_n !== 1'b1 && n < 10) begin
      @(negedge clock);
      n++;
    end
    chk("grant_off", 1, bus_release_grant_n);
    chk("addr_driven", 0, addr_oe_n);
  endtask

  task automatic t_nmi();
    logic sn, si;
    irq_req = 1'b1;
    for (int k = 0; k < 2; k++) begin
      // maskable enabled both times so nmi precedence is really exercised
      irq_enable = 1'b1;
      if (k == 0) begin
        nmi_n_i = 1'b0;
      end
      repeat (6) @(negedge clock);
      instr_end = 1'b1;
      @(negedge clock);
      instr_end = 1'b0;
      {sn, si} = {nmi_take, irq_take};
      @(negedge clock);
      sn |= nmi_take;
      si |= irq_take;
      chk("nmi_take", k == 0, sn);
      chk("irq_take", k == 1, si);
    end
    nmi_n_i = 1'b1;
    irq_req = 1'b0;
  endtask

  task automatic t_pin();
    int n;
    int_reset_req = 1'b1;
    @(negedge clock);
    int_reset_req = 1'b0;
    @(negedge clock);
    chk("pin_pull", 0, reset_pin_n_oe_n);
    chk("core_rst", 0, core_reset_n);
    chk("memory_space_request_n_oe_pin", 1, memory_space_request_n_oe_n);
    n = 1;
    while (reset_pin_n_oe_n === 1'b0 && n < 200) begin
      @(negedge clock);
      n++;
    end
    chk("pull_len", 1, n >= RESET_HOLD_CYC && n <= RESET_HOLD_CYC + 1);
    ext_rst_n = 1'b0;
    repeat (4) @(negedge clock);
    chk("core_rst_ext", 0, core_reset_n);
    chk("io_space_request_n_oe_pin", 1, io_space_request_n_oe_n);
    ext_rst_n = 1'b1;
    acc(1'b0, 1'b0, 1'b0, 24'h000010, 8'h00);
    chk("rdata_after", 8'h3C, req_rdata);
  endtask

  initial begin
    {req_valid, req_write, req_io, req_fetch, instr_end, irq_req, irq_enable} = '0;
    {int_reset_req, slow, rst_b, req_addr, m_addr, req_wdata} = '0;
    {nmi_n_i, bus_release_request_n, m_memory_space_request_n_n, m_io_n, ext_rst_n} = '1;
    miscompares = 0;
    compares = 0;
    repeat (10) @(negedge clock);
    t_reset();
    repeat (10) @(negedge clock);
    rst_b = 1'b1;
    t_mem();
    t_io();
    t_wait();
    t_release();
    t_nmi();
    t_pin();
    tally_and_finish();
  end

  // whole run is a few hundred cycles
  initial begin
    #200us;
    miscompares++;
    tally_and_finish();
  end
endmodule // embi_bus_if_tb
`default_nettype wire

// File: tb/embi_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module embi_mem_model (
  // clock and mode
  input  wire logic        clock,
  input  wire logic        slow,
  // device pins
  input  wire logic [23:0] addr_o,
  input  wire logic [7:0]  data_o,
  input  wire logic        data_oe_n,
  input  wire logic        read_strobe_n_o,
  input  wire logic        write_strobe_n_o,
  // answers
  output logic [7:0]       m_data,
  output logic             wait_n_i
);
  logic [7:0] mem [256];
  logic [7:0] junk_q = 8'h00;
  logic [2:0] busy_q = 3'h0;
  logic       act;
  initial begin
    foreach (mem[i]) begin
      mem[i] = 8'(i) ^ 8'h5A;
    end
  end
  assign act = !read_strobe_n_o || !write_strobe_n_o;
  // released bus shows junk_q, which stays at 00 because negating zero gives zero
  assign m_data = read_strobe_n_o ? junk_q : mem[addr_o[7:0]];
  always @(posedge clock) begin
    junk_q <= ~junk_q + 8'h01;
    busy_q <= act ? busy_q + {2'h0, busy_q != 3'h7} : 3'h0;
    if (!write_strobe_n_o && !data_oe_n) begin
      mem[addr_o[7:0]] <= data_o;
    end
  end
  assign wait_n_i = !(slow && act && busy_q < 3'h4);
endmodule // embi_mem_model
`default_nettype wire
